/* File: hw/jtsm_pkg.sv */
package jtsm_pkg;

   // sixteen controller states, data branch then instruction branch
   typedef enum logic [3:0] {
      ST_TLR,
      ST_IDLE,
      ST_SEL_DR,
      ST_CAP_DR,
      ST_SHIFT_DR,
      ST_EXIT1_DR,
      ST_PAUSE_DR,
      ST_EXIT2_DR,
      ST_UPD_DR,
      ST_SEL_IR,
      ST_CAP_IR,
      ST_SHIFT_IR,
      ST_EXIT1_IR,
      ST_PAUSE_IR,
      ST_EXIT2_IR,
      ST_UPD_IR
   } jtsm_state_t;

   // widths of the scan paths
   localparam int unsigned JTSM_IR_W  = 3;
   localparam int unsigned JTSM_ID_W  = 32;
   localparam int unsigned JTSM_PIN_N = 4;
   localparam int unsigned JTSM_BSR_N = 8;

   // instruction codes
   localparam logic [2:0] JTSM_OP_EXTEST = 3'h0;
   localparam logic [2:0] JTSM_OP_SAMPLE = 3'h1;
   localparam logic [2:0] JTSM_OP_IDCODE = 3'h2;
   localparam logic [2:0] JTSM_OP_BYPASS = 3'h7;

   // fixed pattern loaded by capture-ir
   localparam logic [2:0] JTSM_IR_CAPT = 3'h4;

   // identity word, value is arbitrary
   localparam logic [31:0] JTSM_ID_DEFAULT = 32'h0000_0001;

   // reset values
   localparam logic [7:0] JTSM_BSR_RST = 8'h00;
   localparam logic [3:0] JTSM_PIN_RST = 4'h0;

   // tms-high edges that always reach test-logic-reset
   localparam int unsigned JTSM_TLR_TMS = 5;

   // boundary register selected by the instruction
   function automatic logic jtsm_is_bsr(input logic [2:0] op);
      jtsm_is_bsr = (op == JTSM_OP_EXTEST) || (op == JTSM_OP_SAMPLE);
   endfunction

endpackage

/* File: hw/jtsm_fsm.sv */
`timescale 1ns/10ps
module jtsm_fsm (
   // test clock and reset
   input  wire logic                 tck,
   input  wire logic                 rst_b,
   // mode select
   input  wire logic                 tms,
   // current state
   output jtsm_pkg::jtsm_state_t     state
);
   import jtsm_pkg::*;

   typedef struct packed {
      jtsm_state_t state;
   } jtsm_fsm_t;

   jtsm_fsm_t q;
   jtsm_fsm_t next_q;

   // one step of the controller for a given tms level
   function automatic jtsm_state_t step(input jtsm_state_t s, input logic m);
      jtsm_state_t r;
      r = s;
      unique case (s)
         ST_TLR:      r = m ? ST_TLR      : ST_IDLE;
         ST_IDLE:     r = m ? ST_SEL_DR   : ST_IDLE;
         ST_SEL_DR:   r = m ? ST_SEL_IR   : ST_CAP_DR;
         ST_CAP_DR:   r = m ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_SHIFT_DR: r = m ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR: r = m ? ST_UPD_DR   : ST_PAUSE_DR;
         ST_PAUSE_DR: r = m ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR: r = m ? ST_UPD_DR   : ST_SHIFT_DR;
         ST_UPD_DR:   r = m ? ST_SEL_DR   : ST_IDLE;
         ST_SEL_IR:   r = m ? ST_TLR      : ST_CAP_IR;
         ST_CAP_IR:   r = m ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_SHIFT_IR: r = m ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR: r = m ? ST_UPD_IR   : ST_PAUSE_IR;
         ST_PAUSE_IR: r = m ? ST_EXIT2_IR : ST_PAUSE_IR;
         ST_EXIT2_IR: r = m ? ST_UPD_IR   : ST_SHIFT_IR;
         ST_UPD_IR:   r = m ? ST_SEL_DR   : ST_IDLE;
      endcase
      return r;
   endfunction

   // every path with tms high reaches reset within five edges
   always_comb begin
      next_q       = q;
      next_q.state = step(q.state, tms);
   end

   // power-up lands in test-logic-reset without any tck edge
   always_ff @(posedge tck or negedge rst_b) begin
      if (!rst_b) begin
         q.state <= ST_TLR;
      end else begin
         q <= next_q;
      end
   end

   assign state = q.state;

endmodule

/* File: hw/jtsm_neg.sv */
`timescale 1ns/10ps
module jtsm_neg (
   // test clock and reset
   input  wire logic                 tck,
   input  wire logic                 rst_b,
   // from the rising-edge logic
   input  jtsm_pkg::jtsm_state_t     state,
   input  wire logic [2:0]           ir_sh,
   input  wire logic [7:0]           bsr_sh,
   input  wire logic                 ser,
   // falling-edge results
   output logic      [2:0]           ir_cur,
   output logic                      ext,
   output logic      [7:0]           bsr_upd,
   output logic                      upd_tog,
   output logic                      tdo,
   output logic                      tdo_oe
);
   import jtsm_pkg::*;

   typedef struct packed {
      logic [2:0] ir_cur;
      logic       ext;
      logic [7:0] bsr_upd;
      logic       upd_tog;
      logic       tdo;
      logic       tdo_oe;
   } jtsm_neg_t;

   jtsm_neg_t q;
   jtsm_neg_t next_q;

   // everything here moves on the falling edge, half a tck after the state
   always_comb begin
      next_q        = q;
      next_q.tdo    = ser;
      next_q.tdo_oe = (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);
      if (state == ST_TLR) begin
         next_q.ir_cur = JTSM_OP_IDCODE;
      end
      // instruction changes only here and in test-logic-reset above
      if (state == ST_UPD_IR) begin
         next_q.ir_cur = ir_sh;
      end
      // registered so the other domain never sees a decode glitch
      next_q.ext = (next_q.ir_cur == JTSM_OP_EXTEST);
      // parallel latch of the boundary path
      if ((state == ST_UPD_DR) && jtsm_is_bsr(q.ir_cur)) begin
         next_q.bsr_upd = bsr_sh;
         next_q.upd_tog = ~q.upd_tog;
      end
   end

   always_ff @(negedge tck or negedge rst_b) begin
      if (!rst_b) begin
         q.ir_cur  <= JTSM_OP_IDCODE;
         q.ext     <= 1'b0;
         q.bsr_upd <= JTSM_BSR_RST;
         q.upd_tog <= 1'b0;
         q.tdo     <= 1'b0;
         q.tdo_oe  <= 1'b0;
      end else begin
         q <= next_q;
      end
   end

   assign ir_cur  = q.ir_cur;
   assign ext     = q.ext;
   assign bsr_upd = q.bsr_upd;
   assign upd_tog = q.upd_tog;
   assign tdo     = q.tdo;
   assign tdo_oe  = q.tdo_oe;

endmodule

/* File: hw/jtsm_tap.sv */
// How it works
// - sixteen-state synchronous controller, two branches
// - tms sampled on each rising tck
// - reset state disables tests, loads identity
// - five tms-high edges force reset
// - stays in reset while tms high
// - powers up in reset, no tck
// - idle holds while tms low, registers kept
// - idle with tms high selects data
// - select-dr with tms low captures
// - select-dr with tms high selects instruction
// - instruction fixed during data select/capture/shift
// - capture-dr loads pins for boundary ops
// - capture-dr goes exit1 or shift
// - shift-dr moves selected register toward tdo
// - shift-dr stays on low, exits high
`timescale 1ns/10ps
module jtsm_tap #(
   // identity word, value is arbitrary
   parameter logic [31:0] ID_CODE = jtsm_pkg::JTSM_ID_DEFAULT
) (
   // core clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   // test access pins
   input  wire logic                 tck,
   input  wire logic                 tms,
   input  wire logic                 tdi,
   output logic                      tdo,
   output logic                      tdo_oe,
   // functional pins
   input  wire logic [3:0]           pin_in,
   input  wire logic [3:0]           core_out,
   output logic      [3:0]           pin_out,
   output logic                      test_active
);
   import jtsm_pkg::*;

   // state of the test-clock side
   typedef struct packed {
      logic [2:0]  ir_sh;
      logic [31:0] id_sh;
      logic [7:0]  bsr_sh;
      logic        byp_sh;
      logic [3:0]  pin_s1;
      logic [3:0]  pin_s2;
   } jtsm_tck_t;

   // state of the core-clock side
   typedef struct packed {
      logic       ext_s1;
      logic       ext_s2;
      logic       tog_s1;
      logic       tog_s2;
      logic       tog_s3;
      logic [3:0] upd_word;
      logic [3:0] pin_out;
      logic       test_active;
   } jtsm_clk_t;

   // registers and next values of both domains
   jtsm_tck_t   t;
   jtsm_tck_t   next_t;
   jtsm_clk_t   c;
   jtsm_clk_t   next_c;

   // shared controller view, driven by the two edge modules except ser, which is built here
   jtsm_state_t state;
   logic [2:0]  ir_cur;
   logic        ext;
   logic [7:0]  bsr_upd;
   logic        upd_tog;
   logic        ser;

   // which data register an instruction places between tdi and tdo
   typedef enum logic [1:0] {
      SEL_BSR,
      SEL_ID,
      SEL_BYP
   } jtsm_sel_t;

   // unknown codes fall back to bypass, a safe one-bit path
   function automatic jtsm_sel_t dr_sel(input logic [2:0] op);
      jtsm_sel_t r;
      r = SEL_BYP;
      if (jtsm_is_bsr(op)) begin
         r = SEL_BSR;
      end else if (op == JTSM_OP_IDCODE) begin
         r = SEL_ID;
      end
      return r;
   endfunction

   // serial end of the selected data register
   function automatic logic dr_lsb(input jtsm_sel_t s, input jtsm_tck_t v);
      logic r;
      r = v.byp_sh;
      unique case (s)
         SEL_BSR: r = v.bsr_sh[0];
         SEL_ID:  r = v.id_sh[0];
         SEL_BYP: r = v.byp_sh;
      endcase
      return r;
   endfunction

   jtsm_fsm u_fsm (
      .tck   (tck),
      .rst_b (rst_b),
      .tms   (tms),
      .state (state)
   );

   jtsm_neg u_neg (
      .tck     (tck),
      .rst_b   (rst_b),
      .state   (state),
      .ir_sh   (t.ir_sh),
      .bsr_sh  (t.bsr_sh),
      .ser     (ser),
      .ir_cur  (ir_cur),
      .ext     (ext),
      .bsr_upd (bsr_upd),
      .upd_tog (upd_tog),
      .tdo     (tdo),
      .tdo_oe  (tdo_oe)
   );

   // serial bit handed to the falling-edge tdo flop
   always_comb begin
      if (state == ST_SHIFT_IR) begin
         ser = t.ir_sh[0];
      end else begin
         ser = dr_lsb(dr_sel(ir_cur), t);
      end
   end

   // test-clock side: capture and shift of the scan paths
   always_comb begin
      next_t = t;
      // pins are foreign to tck, two flops before capture
      next_t.pin_s1 = pin_in;
      next_t.pin_s2 = t.pin_s1;
      // only the path named by the state moves, all others hold
      unique case (state)
         ST_CAP_IR: begin
            next_t.ir_sh = JTSM_IR_CAPT;
         end
         ST_SHIFT_IR: begin
            next_t.ir_sh = {tdi, t.ir_sh[2:1]};
         end
         ST_CAP_DR: begin
            unique case (dr_sel(ir_cur))
               SEL_BSR: next_t.bsr_sh = {bsr_upd[7:4], t.pin_s2};
               SEL_ID:  next_t.id_sh  = ID_CODE;
               SEL_BYP: next_t.byp_sh = 1'b0;
            endcase
         end
         ST_SHIFT_DR: begin
            unique case (dr_sel(ir_cur))
               SEL_BSR: next_t.bsr_sh = {tdi, t.bsr_sh[7:1]};
               SEL_ID:  next_t.id_sh  = {tdi, t.id_sh[31:1]};
               SEL_BYP: next_t.byp_sh = tdi;
            endcase
         end
         ST_TLR: begin
            // identity reload is done on the falling edge
         end
         ST_IDLE: begin
            // nothing shifts between scans
         end
         ST_SEL_DR: begin
            // capture waits for capture-dr
         end
         ST_EXIT1_DR: begin
            // last shifted bit stays in place
         end
         ST_PAUSE_DR: begin
            // tester may park tck here for long scans
         end
         ST_EXIT2_DR: begin
            // shifting resumes only in shift-dr
         end
         ST_UPD_DR: begin
            // falling-edge latch reads the stages here
         end

         ST_SEL_IR: begin
            // instruction scan starts in capture-ir
         end
         ST_EXIT1_IR: begin
            // no shift until shift-ir again
         end
         ST_PAUSE_IR: begin
            // instruction path parked, data paths untouched
         end
         ST_EXIT2_IR: begin
            // choice between update and more shifting
         end
         ST_UPD_IR: begin
            // new instruction taken on the falling edge
         end
      endcase
   end

   // shift paths have no functional effect, reset to known values only
   always_ff @(posedge tck or negedge rst_b) begin
      if (!rst_b) begin
         t.ir_sh  <= JTSM_IR_CAPT;
         t.id_sh  <= JTSM_ID_DEFAULT;
         t.bsr_sh <= JTSM_BSR_RST;
         t.byp_sh <= 1'b0;
         t.pin_s1 <= JTSM_PIN_RST;
         t.pin_s2 <= JTSM_PIN_RST;
      end else begin
         t <= next_t;
      end
   end

   // core side: take over the test mode and the latched pin word
   always_comb begin
      next_c        = c;
      // test mode is a level, a plain two-flop sync is enough
      next_c.ext_s1 = ext;
      next_c.ext_s2 = c.ext_s1;
      // update toggle, the third stage only marks the edge
      next_c.tog_s1 = upd_tog;
      next_c.tog_s2 = c.tog_s1;
      next_c.tog_s3 = c.tog_s2;
      // word is stable for many tck periods after the toggle
      if (c.tog_s2 != c.tog_s3) begin
         next_c.upd_word = bsr_upd[7:4];
      end
      // functional path whenever test is off
      if (c.ext_s2) begin
         next_c.pin_out = c.upd_word;
      end else begin
         next_c.pin_out = core_out;
      end
      // status flag follows the synced level
      next_c.test_active = c.ext_s2;
   end

   // pins are driven to JTSM_PIN_RST, not the core path, through reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         c.ext_s1      <= 1'b0;
         c.ext_s2      <= 1'b0;
         c.tog_s1      <= 1'b0;
         c.tog_s2      <= 1'b0;
         c.tog_s3      <= 1'b0;
         c.upd_word    <= JTSM_PIN_RST;
         c.pin_out     <= JTSM_PIN_RST;
         c.test_active <= 1'b0;
      end else begin
         c <= next_c;
      end
   end

   // outputs come straight from the core flops
   assign pin_out     = c.pin_out;
   assign test_active = c.test_active;

endmodule

/* File: tb/jtsm_sva.sv */
`timescale 1ns/10ps
module jtsm_sva #(
   parameter logic [31:0] ID_CODE = 32'h0000_0001
) (
   // clocks and reset
   input wire logic       clk,
   input wire logic       rst_b,
   input wire logic       tck,
   // test pins
   input wire logic       tms,
   input wire logic       tdi,
   input wire logic       tdo,
   input wire logic       tdo_oe,
   // functional pins
   input wire logic [3:0] pin_in,
   input wire logic [3:0] core_out,
   input wire logic [3:0] pin_out,
   input wire logic       test_active
);
   // next state, one nibble per state, for tms low and tms high
   localparam logic [63:0] NX0 = 64'h1bdd_bba1_4664_4311;
   localparam logic [63:0] NX1 = 64'h2fef_cc02_8785_5920;
   logic [3:0] st;
   logic [2:0] hi_n;
   logic       id_sel;
   // shadow controller, since the ports alone hide the state
   always_ff @(posedge tck or negedge rst_b) begin
      if (!rst_b) begin
         st     <= 4'h0;
         hi_n   <= 3'h0;
         id_sel <= 1'b1;
      end else begin
         st     <= tms ? NX1[{st, 2'b00} +: 4] : NX0[{st, 2'b00} +: 4];
         hi_n   <= !tms ? 3'h0 : hi_n + {2'b00, hi_n != 3'h7};
         id_sel <= (st == 4'h0) || (id_sel && st != 4'hf);
      end
   end
   property p_oe;
      @(posedge tck) disable iff (!rst_b) tdo_oe == (st == 4'h4 || st == 4'hb);
   endproperty
   a_oe: assert property (p_oe) else $error("tdo_oe off shift state");
   property p_rst5;
      @(posedge tck) disable iff (!rst_b) hi_n >= 3'h5 |-> !tdo_oe;
   endproperty
   a_rst5: assert property (p_rst5) else $error("no reset after highs");
   property p_tlr_off;
      @(posedge tck) disable iff (!rst_b) hi_n >= 3'h6 |-> !test_active;
   endproperty
   a_tlr_off: assert property (p_tlr_off) else $error("test mode in reset");
   property p_ir_capt;
      @(posedge tck) disable iff (!rst_b)
         (st == 4'ha) ##1 (st == 4'hb) |-> !tdo ##1 (st != 4'hb || !tdo) ##1 (st != 4'hb || tdo);
   endproperty
   a_ir_capt: assert property (p_ir_capt) else $error("bad ir capture");
   property p_idc;
      @(posedge tck) disable iff (!rst_b)
         (id_sel && st == 4'h3) ##1 (st == 4'h4) |-> tdo == ID_CODE[0];
   endproperty
   a_idc: assert property (p_idc) else $error("identity bit0 wrong");
   property p_hold;
      @(posedge tck) disable iff (!rst_b) (st == 4'h3 || st == 4'h4) |=> $stable(test_active);
   endproperty
   a_hold: assert property (p_hold) else $error("instruction moved in scan");
   property p_norm;
      @(posedge clk) disable iff (!rst_b) (!test_active) [*4] |-> pin_out == $past(core_out);
   endproperty
   a_norm: assert property (p_norm) else $error("pin_out not core_out");
   property p_pwr;
      @(posedge clk) disable iff (!rst_b) $rose(rst_b) |-> !test_active && pin_out == 4'h0;
   endproperty
   a_pwr: assert property (p_pwr) else $error("bad state after reset");
endmodule

/* File: tb/jtsm_tester.sv */
`timescale 1ns/10ps
module jtsm_tester (
   // test pins toward the device
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   // tck rests low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #32 tck = 1'b1;
      q = tdo;
      #32 tck = 1'b0;
   endtask
endmodule

/* File: tb/jtag_tap_dr_path_controller_tb.sv */
`timescale 1ns/10ps
module jtag_tap_dr_path_controller_tb;
   import jtsm_pkg::*;
   // identity word, value is arbitrary
   localparam logic [31:0] ID = 32'h1357_9bdf;
   logic       clk, rst_b, tck, tms, tdi, tdo, tdo_oe, test_active;
   logic [3:0] pin_in, core_out, pin_out;
   int         error_cnt;
   int         n_checks;
   // tdo released outside shift floats to its pull-up
   wire        tdo_line = tdo_oe ? tdo : 1'b1;

   jtsm_tap #(.ID_CODE(ID)) i_dut (.clk(clk), .rst_b(rst_b), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out),
      .pin_out(pin_out), .test_active(test_active));
   jtsm_tester i_tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));

   // core clock
   always #5 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // tms levels lsb first, tdo ignored
   task automatic walk(input logic [7:0] m, input int n);
      logic q;
      for (int i = 0; i < n; i++) i_tst.step(m[i], 1'b0, q);
   endtask
   // idle to idle, n data bits lsb first
   task automatic dr_scan(input int n, input logic [31:0] din, output logic [31:0] dout);
      logic q;
      dout = '0;
      walk(8'h01, 3);
      for (int i = 0; i < n; i++) begin
         i_tst.step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      walk(8'h01, 2);
   endtask
   task automatic ir_load(input logic [2:0] op, output logic [2:0] cap);
      logic q;
      walk(8'h03, 4);
      for (int i = 0; i < 3; i++) begin
         i_tst.step(i == 2, op[i], q);
         cap[i] = q;
      end
      walk(8'h01, 2);
   endtask
   // six highs then idle; one more than needed on purpose
   task automatic to_idle;
      walk(8'h3f, 7);
   endtask
   task automatic set_pins(input logic [3:0] p, input logic [3:0] c);
      @(negedge clk);
      pin_in = p;
      core_out = c;
   endtask
   // pin crossing takes a few core clocks, so poll with a bound
   task automatic wait_pin(input logic [3:0] exp);
      int k;
      k = 0;
      while (pin_out !== exp && k < 20) begin
         @(negedge clk);
         k++;
      end
      chk(pin_out, exp);
      if (pin_out !== exp) finish_test();
   endtask

   task automatic t_reset;
      set_pins(4'h9, 4'ha);
      @(negedge clk);
      chk(pin_out, 4'ha);
      chk(test_active, 1'b0);
      chk(tdo_oe, 1'b0);
      $display("t_reset done");
   endtask
   task automatic t_paths;
      logic [2:0]  c;
      logic [31:0] d;
      to_idle();
      dr_scan(32, 32'h0, d);
      chk(d, ID);
      ir_load(JTSM_OP_BYPASS, c);
      chk(c, 3'h4);
      dr_scan(5, 32'h16, d);
      chk(d, 32'h0c);
      walk(8'h03, 6);
      to_idle();
      dr_scan(32, 32'h0, d);
      chk(d, ID);
      ir_load(JTSM_OP_BYPASS, c);
      walk(8'h0f, 5);
      dr_scan(32, 32'h0, d);
      chk(d, ID);
      $display("t_paths done");
   endtask
   task automatic t_extest;
      logic [2:0]  c;
      logic [31:0] d;
      set_pins(4'h9, 4'h5);
      ir_load(JTSM_OP_SAMPLE, c);
      dr_scan(8, 32'h60, d);
      chk(d, 32'h09);
      ir_load(JTSM_OP_EXTEST, c);
      walk(8'h00, 4);
      wait_pin(4'h6);
      chk(test_active, 1'b1);
      set_pins(4'h3, 4'h5);
      dr_scan(8, 32'ha0, d);
      chk(d, 32'h63);
      wait_pin(4'ha);
      to_idle();
      wait_pin(4'h5);
      chk(test_active, 1'b0);
      $display("t_extest done");
   endtask
   // reset in mid-run, no tck needed to land in test-logic-reset
   task automatic t_rst_mid;
      logic [2:0]  c;
      logic [31:0] d;
      ir_load(JTSM_OP_EXTEST, c);
      wait_pin(4'ha);
      set_pins(4'h3, 4'h6);
      rst_b = 1'b0;
      repeat (5) @(negedge clk);
      chk(pin_out, 4'h0);
      chk(test_active, 1'b0);
      chk(tdo_oe, 1'b0);
      rst_b = 1'b1;
      @(negedge clk);
      chk(pin_out, 4'h6);
      walk(8'h00, 1);
      dr_scan(32, 32'h0, d);
      chk(d, ID);
      $display("t_rst_mid done");
   endtask

   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      pin_in = 4'h0;
      core_out = 4'h0;
      error_cnt = 0;
      n_checks = 0;
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      t_reset();
      t_paths();
      t_extest();
      t_rst_mid();
      finish_test();
   end
endmodule

bind jtsm_tap jtsm_sva #(.ID_CODE(ID_CODE)) i_sva (.clk(clk), .rst_b(rst_b), .tck(tck),
   .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out),
   .pin_out(pin_out), .test_active(test_active));
